// >>> src/mqp_evt_irq.sv
// Sticky event status with write-one-to-clear, enable mask and one
// level interrupt. Assumes one clock domain and one-cycle event pulses.
`timescale 1ns/1ps
module mqp_evt_irq
  import mqp_pkg::*;
#(
  parameter int N = MQP_NEVT
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Events and register writes
  input wire logic [N-1:0] set_i,
  input wire logic clr_we_i,
  input wire logic en_we_i,
  input wire logic [N-1:0] wdata_i,
  // State and interrupt
  output logic [N-1:0] status_o,
  output logic [N-1:0] enable_o,
  output logic irq_o
);
  logic [N-1:0] sts_ff, nxt_sts, en_ff, nxt_en;

  always_comb begin
    nxt_sts = sts_ff;
    nxt_en = en_ff;
    if (clr_we_i) nxt_sts = sts_ff & ~wdata_i;
    // A new event in the clearing cycle survives the clear.
    nxt_sts = nxt_sts | set_i;
    if (en_we_i) nxt_en = wdata_i;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      sts_ff <= '0;
      en_ff <= MQP_EVEN_RST;
    end else begin
      sts_ff <= nxt_sts;
      en_ff <= nxt_en;
    end
  end

  assign status_o = sts_ff;
  assign enable_o = en_ff;
  assign irq_o = |(sts_ff & en_ff);

endmodule : mqp_evt_irq

// >>> src/mqp_fifo.sv
// One message queue: a word FIFO that drops pushes when full.
// Assumes DEPTH is a power of two and one clock domain.
`timescale 1ns/1ps
module mqp_fifo
  import mqp_pkg::*;
#(
  parameter int DW = MQP_DW,
  parameter int DEPTH = MQP_QDEPTH,
  parameter int CW = $clog2(DEPTH + 1)
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic flush_i,
  // Fill side
  input wire logic push_i,
  input wire logic [DW-1:0] data_i,
  // Drain side
  input wire logic pop_i,
  output logic [DW-1:0] data_o,
  // Occupancy
  output logic empty_o,
  output logic full_o,
  output logic [CW-1:0] count_o
);
  localparam int PW = $clog2(DEPTH);

  logic [DW-1:0] mem [DEPTH];
  logic [PW-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [CW-1:0] cnt_ff, nxt_cnt;
  logic do_push, do_pop;

  assign empty_o = (cnt_ff == '0);
  assign full_o = (cnt_ff == CW'(DEPTH));
  assign count_o = cnt_ff;
  assign data_o = mem[rp_ff];

  always_comb begin
    do_push = push_i && !full_o;  // see [R8]
    do_pop = pop_i && !empty_o;  // see [R7]
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    nxt_cnt = cnt_ff;
    if (flush_i) begin
      nxt_wp = '0;  // see [R9]
      nxt_rp = '0;
      nxt_cnt = '0;
    end else begin
      if (do_push) nxt_wp = wp_ff + PW'(1);
      if (do_pop) nxt_rp = rp_ff + PW'(1);
      nxt_cnt = cnt_ff + CW'(do_push) - CW'(do_pop);  // see [R14]
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wp_ff <= '0;
      rp_ff <= '0;
      cnt_ff <= '0;
    end else begin
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage is not reset; the pointers and the count define what is valid.
  always_ff @(posedge clk_i) begin
    if (do_push && !flush_i) mem[wp_ff] <= data_i;
  end

  property p_drop_full;
    @(posedge clk_i) disable iff (srst_i)
    push_i && full_o && !pop_i && !flush_i |=>
      count_o == $past(count_o) && data_o == $past(data_o);
  endproperty
  a_drop_full: assert property (p_drop_full)  // see [R8]
    else $error("push into full queue changed it");

  property p_flush;
    @(posedge clk_i) disable iff (srst_i)
    flush_i |=> empty_o && !full_o;
  endproperty
  a_flush: assert property (p_flush)  // see [R9]
    else $error("flush left queue non-empty");

  property p_accept;
    @(posedge clk_i) disable iff (srst_i)
    push_i && !full_o && !pop_i && !flush_i |=>
      count_o == $past(count_o) + CW'(1);
  endproperty
  a_accept: assert property (p_accept)  // see [R14]
    else $error("accepted push did not grow queue");

endmodule : mqp_fifo

// >>> src/mqp_pkg.sv
// Constants, queue ids and port decode for the message queue ports block.
// Assumes a 12-bit APB byte address and 32-bit data words.
package mqp_pkg;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int MQP_DW = 32;
  localparam int MQP_AW = 12;
  localparam int MQP_QDEPTH = 32;
  localparam int MQP_NQ = 4;
  localparam int MQP_NEVT = 4;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] MQP_OFS_HSTAT = 12'h030;
  localparam logic [11:0] MQP_OFS_HMASK = 12'h034;
  localparam logic [11:0] MQP_OFS_LSTAT = 12'h038;
  localparam logic [11:0] MQP_OFS_LMASK = 12'h03C;
  localparam logic [11:0] MQP_OFS_PORT0 = 12'h040;
  localparam logic [11:0] MQP_OFS_PORT1 = 12'h044;
  localparam logic [11:0] MQP_OFS_PORT2 = 12'h048;
  localparam logic [11:0] MQP_OFS_PORT3 = 12'h04C;
  localparam logic [11:0] MQP_OFS_EVSTAT = 12'h050;
  localparam logic [11:0] MQP_OFS_EVEN = 12'h054;

  // ----------------------------------------------------------------------
  // Fields and reset values
  // ----------------------------------------------------------------------
  localparam int MQP_MSG_BIT = 3;
  localparam logic MQP_MASK_RST = 1'b1;
  localparam logic [MQP_NEVT-1:0] MQP_EVEN_RST = 4'h0;
  localparam logic [31:0] MQP_ONES = 32'hFFFFFFFF;
  localparam logic [31:0] MQP_ZERO = 32'h00000000;
  localparam int MQP_EV_DROP = 0;
  localparam int MQP_EV_EMPTY_RD = 1;
  localparam int MQP_EV_IPOST = 2;
  localparam int MQP_EV_OPOST = 3;

  // ----------------------------------------------------------------------
  // Queue ids and shared port decode
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    MQP_Q_IFREE = 2'h0,
    MQP_Q_IPOST = 2'h1,
    MQP_Q_OPOST = 2'h3,
    MQP_Q_OFREE = 2'h2
  } mqp_queue_t;

  function automatic mqp_queue_t mqp_rd_q(input logic [1:0] port);
    case (port)
      2'h0: mqp_rd_q = MQP_Q_IFREE;
      2'h1: mqp_rd_q = MQP_Q_OPOST;
      2'h2: mqp_rd_q = MQP_Q_IPOST;
      default: mqp_rd_q = MQP_Q_OFREE;
    endcase
  endfunction : mqp_rd_q

  function automatic mqp_queue_t mqp_wr_q(input logic [1:0] port);
    case (port)
      2'h0: mqp_wr_q = MQP_Q_IPOST;
      2'h1: mqp_wr_q = MQP_Q_OFREE;
      2'h2: mqp_wr_q = MQP_Q_IFREE;
      default: mqp_wr_q = MQP_Q_OPOST;
    endcase
  endfunction : mqp_wr_q

endpackage : mqp_pkg

// >>> src/mqp_top.sv
// Message queue ports: four 32-entry queues behind four shared APB ports,
// with local and host message interrupt status and mask bits.
// Assumes an APB3 master on clk_i and an asynchronous PCI reset pin.
//
// Functional notes
// [R1] Local message mask bit: one blocks, zero passes, resets to one.
// [R2] Local mask register reads one in every bit without a field.
// [R3] Port 0x0040 reads inbound free queue, writes inbound post queue.
// [R4] Port 0x0044 reads outbound post queue, writes outbound free queue.
// [R5] Port 0x0048 reads inbound post queue, writes inbound free queue.
// [R6] Port 0x004C reads outbound free queue, writes outbound post queue.
// [R7] Reading an empty queue returns all ones and leaves it unchanged.
// [R8] A write into a full queue is dropped; queue stays as it was.
// [R9] Queues start empty; PCI reset flushes all four queues.
// [R10] Local status bit is one while inbound post queue is non-empty.
// [R11] Host status bit 3 is one while outbound post queue is non-empty.
// [R12] Host message mask bit: one blocks, zero passes, resets to one.
// [R13] Each message interrupt is high only when status is one, mask zero.
// [R14] Each queue holds up to 32 words of 32 bits with full/empty.
`timescale 1ns/1ps
module mqp_top
  import mqp_pkg::*;
#(
  parameter int DEPTH = MQP_QDEPTH
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // PCI reset pin, asynchronous, active high
  input wire logic pci_rst_i,
  // APB slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [MQP_AW-1:0] paddr_i,
  input wire logic [MQP_DW-1:0] pwdata_i,
  output logic [MQP_DW-1:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // Interrupts
  output logic local_irq_o,
  output logic host_irq_o,
  output logic evt_irq_o
);
  localparam int CW = $clog2(DEPTH + 1);

  // ----------------------------------------------------------------------
  // PCI reset synchroniser
  // ----------------------------------------------------------------------
  logic prst_meta_ff, prst_sync_ff;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      prst_meta_ff <= 1'b0;
      prst_sync_ff <= 1'b0;
    end else begin
      prst_meta_ff <= pci_rst_i;
      prst_sync_ff <= prst_meta_ff;
    end
  end

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic setup, acc, wr_acc, rd_acc, is_q, mapped;
  mqp_queue_t rq, wq;

  assign setup = psel_i && !penable_i;
  assign acc = psel_i && penable_i;
  assign wr_acc = acc && pwrite_i;
  assign rd_acc = acc && !pwrite_i;
  assign is_q = (paddr_i[11:4] == MQP_OFS_PORT0[11:4]) &&
                (paddr_i[1:0] == 2'h0);
  assign rq = mqp_rd_q(paddr_i[3:2]);  // see [R3] [R4] [R5] [R6]
  assign wq = mqp_wr_q(paddr_i[3:2]);  // see [R3] [R4] [R5] [R6]

  // Zero wait states: read data is captured during the setup cycle.
  assign pready_o = 1'b1;
  assign pslverr_o = acc && !mapped;

  // ----------------------------------------------------------------------
  // Queues
  // ----------------------------------------------------------------------
  logic [MQP_NQ-1:0] push, pop, empty, full;
  logic [MQP_DW-1:0] head [MQP_NQ];
  logic [CW-1:0] cnt [MQP_NQ];

  always_comb begin
    push = '0;
    pop = '0;
    if (wr_acc && is_q) push[wq] = 1'b1;
    if (rd_acc && is_q && !empty[rq]) pop[rq] = 1'b1;  // see [R7]
  end

  for (genvar g = 0; g < MQP_NQ; g++) begin : g_q
    mqp_fifo #(
      .DW(MQP_DW),
      .DEPTH(DEPTH),
      .CW(CW)
    ) u_q (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .flush_i(prst_sync_ff),  // see [R9]
      .push_i(push[g]),
      .data_i(pwdata_i),
      .pop_i(pop[g]),
      .data_o(head[g]),
      .empty_o(empty[g]),
      .full_o(full[g]),
      .count_o(cnt[g])
    );
  end

  logic ipost_ne, opost_ne;

  assign ipost_ne = !empty[MQP_Q_IPOST];  // see [R10]
  assign opost_ne = !empty[MQP_Q_OPOST];  // see [R11]

  // ----------------------------------------------------------------------
  // Event status and its interrupt
  // ----------------------------------------------------------------------
  logic [MQP_NEVT-1:0] evt_set, evt_sts, evt_en;

  always_comb begin
    evt_set = '0;
    evt_set[MQP_EV_DROP] = |(push & full);
    evt_set[MQP_EV_EMPTY_RD] = rd_acc && is_q && empty[rq];
    evt_set[MQP_EV_IPOST] = push[MQP_Q_IPOST] && !full[MQP_Q_IPOST];
    evt_set[MQP_EV_OPOST] = push[MQP_Q_OPOST] && !full[MQP_Q_OPOST];
  end

  mqp_evt_irq #(
    .N(MQP_NEVT)
  ) u_irq (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .set_i(evt_set),
    .clr_we_i(wr_acc && paddr_i == MQP_OFS_EVSTAT),
    .en_we_i(wr_acc && paddr_i == MQP_OFS_EVEN),
    .wdata_i(pwdata_i[MQP_NEVT-1:0]),
    .status_o(evt_sts),
    .enable_o(evt_en),
    .irq_o(evt_irq_o)
  );

  // ----------------------------------------------------------------------
  // Mask registers and read data
  // ----------------------------------------------------------------------
  logic lmask_ff, nxt_lmask, hmask_ff, nxt_hmask;
  logic [MQP_DW-1:0] prdata_ff, nxt_prdata, rd_val;

  always_comb begin
    rd_val = MQP_ZERO;
    mapped = 1'b1;
    case (paddr_i)
      MQP_OFS_HSTAT: rd_val[MQP_MSG_BIT] = opost_ne;  // see [R11]
      MQP_OFS_HMASK: begin
        rd_val = MQP_ONES;
        rd_val[MQP_MSG_BIT] = hmask_ff;
      end
      MQP_OFS_LSTAT: rd_val[MQP_MSG_BIT] = ipost_ne;  // see [R10]
      MQP_OFS_LMASK: begin
        rd_val = MQP_ONES;  // see [R2]
        rd_val[MQP_MSG_BIT] = lmask_ff;
      end
      MQP_OFS_EVSTAT: rd_val[MQP_NEVT-1:0] = evt_sts;
      MQP_OFS_EVEN: rd_val[MQP_NEVT-1:0] = evt_en;
      default: begin
        if (is_q) begin
          rd_val = empty[rq] ? MQP_ONES : head[rq];  // see [R7]
        end else begin
          mapped = 1'b0;
        end
      end
    endcase
  end

  always_comb begin
    nxt_lmask = lmask_ff;
    nxt_hmask = hmask_ff;
    nxt_prdata = prdata_ff;
    if (wr_acc && paddr_i == MQP_OFS_LMASK) begin
      nxt_lmask = pwdata_i[MQP_MSG_BIT];  // see [R1]
    end
    if (wr_acc && paddr_i == MQP_OFS_HMASK) begin
      nxt_hmask = pwdata_i[MQP_MSG_BIT];  // see [R12]
    end
    if (setup && !pwrite_i) nxt_prdata = rd_val;
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      lmask_ff <= MQP_MASK_RST;  // see [R1]
      hmask_ff <= MQP_MASK_RST;  // see [R12]
      prdata_ff <= MQP_ZERO;
    end else begin
      lmask_ff <= nxt_lmask;
      hmask_ff <= nxt_hmask;
      prdata_ff <= nxt_prdata;
    end
  end

  assign prdata_o = prdata_ff;
  assign local_irq_o = ipost_ne && !lmask_ff;  // see [R13]
  assign host_irq_o = opost_ne && !hmask_ff;  // see [R13]

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_rd(logic [11:0] a);
    psel_i && !penable_i && !pwrite_i && paddr_i == a;
  endsequence

  sequence s_wr(logic [11:0] a);
    psel_i && penable_i && pwrite_i && paddr_i == a && !prst_sync_ff;
  endsequence

  property p_lmask_rst;
    @(posedge clk_i) disable iff (srst_i)
    $fell(srst_i) |-> lmask_ff && !local_irq_o;
  endproperty
  a_lmask_rst: assert property (p_lmask_rst)  // see [R1]
    else $error("local mask not set after reset");

  property p_lmask_ones;
    @(posedge clk_i) disable iff (srst_i)
    s_rd(MQP_OFS_LMASK) |=>
      (prdata_o | (MQP_DW'(1) << MQP_MSG_BIT)) == MQP_ONES;
  endproperty
  a_lmask_ones: assert property (p_lmask_ones)  // see [R2]
    else $error("local mask unused bits not ones");

  property p_port0;
    @(posedge clk_i) disable iff (srst_i)
    s_wr(MQP_OFS_PORT0) ##0 !full[MQP_Q_IPOST] |=>
      cnt[MQP_Q_IPOST] == $past(cnt[MQP_Q_IPOST]) + CW'(1);
  endproperty
  a_port0: assert property (p_port0)  // see [R3]
    else $error("port 0 write missed inbound post queue");

  property p_port1;
    @(posedge clk_i) disable iff (srst_i)
    psel_i && penable_i && !pwrite_i && paddr_i == MQP_OFS_PORT1 &&
      !empty[MQP_Q_OPOST] && !prst_sync_ff |=>
      cnt[MQP_Q_OPOST] == $past(cnt[MQP_Q_OPOST]) - CW'(1);
  endproperty
  a_port1: assert property (p_port1)  // see [R4]
    else $error("port 1 read missed outbound post queue");

  property p_port2;
    @(posedge clk_i) disable iff (srst_i)
    s_rd(MQP_OFS_PORT2) ##0 !empty[MQP_Q_IPOST] |=>
      prdata_o == $past(head[MQP_Q_IPOST]);
  endproperty
  a_port2: assert property (p_port2)  // see [R5]
    else $error("port 2 read data not inbound post head");

  property p_port3;
    @(posedge clk_i) disable iff (srst_i)
    s_wr(MQP_OFS_PORT3) ##0 !full[MQP_Q_OPOST] |=>
      opost_ne ##0 (evt_sts[MQP_EV_OPOST]);
  endproperty
  a_port3: assert property (p_port3)  // see [R6]
    else $error("port 3 write missed outbound post queue");

  property p_empty_rd;
    @(posedge clk_i) disable iff (srst_i)
    s_rd(MQP_OFS_PORT0) ##0 empty[MQP_Q_IFREE] |=>
      prdata_o == MQP_ONES;
  endproperty
  a_empty_rd: assert property (p_empty_rd)  // see [R7]
    else $error("empty read did not return all ones");

  property p_flush_all;
    @(posedge clk_i) disable iff (srst_i)
    prst_sync_ff |=> empty == '1 ##1 !local_irq_o && !host_irq_o;
  endproperty
  a_flush_all: assert property (p_flush_all)  // see [R9]
    else $error("PCI reset did not empty all queues");

  property p_lstat;
    @(posedge clk_i) disable iff (srst_i)
    s_rd(MQP_OFS_LSTAT) |=> prdata_o[MQP_MSG_BIT] == $past(ipost_ne);
  endproperty
  a_lstat: assert property (p_lstat)  // see [R10]
    else $error("local status does not track inbound post");

  property p_hstat;
    @(posedge clk_i) disable iff (srst_i)
    s_rd(MQP_OFS_HSTAT) |=> prdata_o == ($past(opost_ne) ?
      (MQP_DW'(1) << MQP_MSG_BIT) : MQP_ZERO);
  endproperty
  a_hstat: assert property (p_hstat)  // see [R11]
    else $error("host status does not track outbound post");

  property p_hmask_rst;
    @(posedge clk_i) disable iff (srst_i)
    $fell(srst_i) |-> hmask_ff && !host_irq_o;
  endproperty
  a_hmask_rst: assert property (p_hmask_rst)  // see [R12]
    else $error("host mask not set after reset");

  property p_irq;
    @(posedge clk_i) disable iff (srst_i)
    s_wr(MQP_OFS_PORT0) ##0 !lmask_ff && !full[MQP_Q_IPOST] |=>
      local_irq_o;
  endproperty
  a_irq: assert property (p_irq)  // see [R13]
    else $error("unmasked inbound post gave no interrupt");

endmodule : mqp_top

// >>> verification/message_queue_ports_test.sv
// Self-checking bench for the message queue ports with a queue model.
// Assumes the APB master model and a shortened queue depth of four.
`timescale 1ns/1ps
module message_queue_ports_test
  import mqp_pkg::*;
;
  localparam int DEPTH = 4;
  logic clk_i;
  logic srst_i;
  logic pci_rst_i;
  logic psel, penable, pwrite, pready, pslverr;
  logic [MQP_AW-1:0] paddr;
  logic [MQP_DW-1:0] pwdata, prdata, got;
  logic local_irq_o, host_irq_o, evt_irq_o, err;
  int n_errors = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h0000005E;
  logic [31:0] mq[4][$];
  logic lmask = 1'b1;
  logic hmask = 1'b1;
  // Model queues: 0 inbound free, 1 inbound post, 2 outbound post, 3 free.
  int rdq[4] = '{0, 2, 1, 3};
  int wrq[4] = '{1, 3, 0, 2};

  mqp_top #(.DEPTH(DEPTH)) dut (.clk_i(clk_i), .srst_i(srst_i),
    .pci_rst_i(pci_rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .local_irq_o(local_irq_o), .host_irq_o(host_irq_o),
    .evt_irq_o(evt_irq_o));
  mqp_apb_host u_host (.clk_i(clk_i), .psel_o(psel), .penable_o(penable),
    .pwrite_o(pwrite), .paddr_o(paddr), .pwdata_o(pwdata),
    .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr));

  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  task automatic check(input string name, input logic [31:0] exp,
      input logic [31:0] act);
    tests_run++;
    if (act !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, act);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  task automatic check_irq();
    @(negedge clk_i);
    check("local irq", {31'h0, mq[1].size() != 0 && !lmask},
      {31'h0, local_irq_o});
    check("host irq", {31'h0, mq[2].size() != 0 && !hmask},
      {31'h0, host_irq_o});
  endtask : check_irq

  task automatic check_regs();
    u_host.xfer(1'b0, MQP_OFS_LSTAT, '0, got, err);
    check("local status", {28'h0, mq[1].size() != 0, 3'h0}, got);
    u_host.xfer(1'b0, MQP_OFS_HSTAT, '0, got, err);
    check("host status", {28'h0, mq[2].size() != 0, 3'h0}, got);
    u_host.xfer(1'b0, MQP_OFS_LMASK, '0, got, err);
    check("local mask", {28'hFFFFFFF, lmask, 3'h7}, got);
    u_host.xfer(1'b0, MQP_OFS_HMASK, '0, got, err);
    check("host mask", {28'hFFFFFFF, hmask, 3'h7}, got);
  endtask : check_regs

  task automatic set_masks(input logic l, input logic h);
    lmask = l;
    hmask = h;
    u_host.xfer(1'b1, MQP_OFS_LMASK, {28'h0, l, 3'h0}, got, err);
    u_host.xfer(1'b1, MQP_OFS_HMASK, {28'h0, h, 3'h0}, got, err);
    check_irq();
  endtask : set_masks

  // The model drops pushes into a full queue and answers all ones when
  // a read finds its queue empty.
  task automatic port_op(input logic wr, input logic [1:0] p,
      input logic [31:0] d);
    logic [31:0] exp;
    exp = MQP_ONES;
    if (wr && mq[wrq[p]].size() < DEPTH)
      mq[wrq[p]].push_back(d);
    if (!wr && mq[rdq[p]].size() != 0)
      exp = mq[rdq[p]].pop_front();
    u_host.xfer(wr, MQP_OFS_PORT0 + {8'h00, p, 2'b00}, d, got, err);
    if (!wr)
      check("port read", exp, got);
    check_irq();
  endtask : port_op

  // ----------------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] r;
    srst_i = 1'b1;
    pci_rst_i = 1'b0;
    repeat (8) @(posedge clk_i);
    srst_i <= 1'b0;
    check_regs();
    for (int p = 0; p < 4; p++) port_op(1'b0, p[1:0], '0);
    set_masks(1'b0, 1'b0);
    check_regs();
    u_host.xfer(1'b1, MQP_OFS_EVEN, 32'h00000001, got, err);
    for (int i = 0; i < DEPTH + 2; i++) port_op(1'b1, 2'h0, xs());
    check_regs();
    @(negedge clk_i);
    check("event irq", 32'h1, {31'h0, evt_irq_o});
    u_host.xfer(1'b1, MQP_OFS_EVSTAT, 32'h0000000F, got, err);
    @(negedge clk_i);
    check("event irq", 32'h0, {31'h0, evt_irq_o});
    for (int i = 0; i < DEPTH + 1; i++) port_op(1'b0, 2'h2, '0);
    for (int i = 0; i < 300; i++) begin
      r = xs();
      if (r[7:4] == 4'h0)
        set_masks(r[8], r[9]);
      else
        port_op(r[2], r[1:0], xs());
      if (r[7:4] == 4'h1)
        check_regs();
    end
    for (int i = 0; i < 4; i++) port_op(1'b1, i[1:0], xs());
    @(posedge clk_i);
    pci_rst_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    pci_rst_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    for (int q = 0; q < 4; q++) mq[q].delete();
    check_regs();
    for (int p = 0; p < 4; p++) port_op(1'b0, p[1:0], '0);
    u_host.xfer(1'b0, 12'h100, '0, got, err);
    check("unmapped error", 32'h1, {31'h0, err});
    complete_run();
  end

  initial begin
    #(100 * 20000);
    n_errors++;
    complete_run();
  end
endmodule : message_queue_ports_test

// >>> verification/mqp_apb_host.sv
// APB master model for the host and local processor side of the ports.
// Assumes one clock; the bench calls xfer for every bus transfer.
`timescale 1ns/1ps
module mqp_apb_host
  import mqp_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // APB master side
  output logic psel_o,
  output logic penable_o,
  output logic pwrite_o,
  output logic [MQP_AW-1:0] paddr_o,
  output logic [MQP_DW-1:0] pwdata_o,
  input wire logic [MQP_DW-1:0] prdata_i,
  input wire logic pready_i,
  input wire logic pslverr_i
);
  initial begin
    psel_o = 1'b0;
    penable_o = 1'b0;
    pwrite_o = 1'b0;
    paddr_o = '0;
    pwdata_o = '0;
  end

  // The request holds until pready is seen high; released lines are
  // inverted so that nothing can lean on a stale address or data word.
  task automatic xfer(input logic wr, input logic [MQP_AW-1:0] addr,
      input logic [MQP_DW-1:0] wdata, output logic [MQP_DW-1:0] rdata,
      output logic err);
    @(posedge clk_i);
    psel_o <= 1'b1;
    penable_o <= 1'b0;
    pwrite_o <= wr;
    paddr_o <= addr;
    pwdata_o <= wdata;
    @(posedge clk_i);
    penable_o <= 1'b1;
    @(posedge clk_i);
    while (pready_i !== 1'b1) begin
      @(posedge clk_i);
    end
    rdata = prdata_i;
    err = pslverr_i;
    psel_o <= 1'b0;
    penable_o <= 1'b0;
    paddr_o <= ~addr;
    pwdata_o <= ~wdata;
  endtask : xfer
endmodule : mqp_apb_host
